// >>> rtl/tbw_core.sv
// command core: initiate, select, block write, identifier fetch
// assumes bit-serial link: rx_clk/rx_dat/rx_frame from a demodulator,
// answer bytes leave through a valid/ready byte port with a last flag
`timescale 1ns/1ps
module tbw_core #(
  parameter int unsigned PROG_OTP = tbw_pkg::CYC_OTP, // otp write cycles
  parameter int unsigned PROG_EE = tbw_pkg::CYC_EE, // storage cycles
  parameter int unsigned PROG_CNT = tbw_pkg::CYC_CNT, // counter cycles
  parameter logic [15:0] PROT_MASK = 16'h0000 // write-protected blocks
) (
  input wire logic clk, // system clock 40 MHz
  input wire logic resetn, // power-on reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic rx_clk, // link bit clock, async
  input wire logic rx_dat, // link data, sampled on rx_clk rise
  input wire logic rx_frame, // high during a request frame
  output logic tx_valid, // answer byte offered
  input wire logic tx_ready, // link takes answer byte
  output logic [7:0] tx_data, // answer byte
  output logic tx_last, // last byte of the answer frame
  output logic load_mod, // load modulation enable
  output logic low_power, // low-power condition
  output logic selected, // in selected state
  output logic busy, // programming in progress
  output logic [31:0] blk_data [16] // block contents view
);
  // two-flop synchronisers
  logic [2:0] s1_reg, s2_reg;
  logic clk_d_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      clk_d_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= {rx_frame, rx_dat, rx_clk};
      s2_reg <= s1_reg;
      clk_d_reg <= s2_reg[0];
    end
  end
  logic bit_stb, frame_s, dat_s, frame_d_reg, frame_end;
  assign frame_s = s2_reg[2];
  assign dat_s = s2_reg[1];
  assign bit_stb = s2_reg[0] && !clk_d_reg && frame_s;
  assign frame_end = frame_d_reg && !frame_s;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) frame_d_reg <= 1'b0;
    else if (ce) frame_d_reg <= frame_s;
  end

  // deserialise, lsb first; bytes stored in order
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic [3:0] nbyte_reg;
  logic [7:0] rq [tbw_pkg::MAX_REQ + 2];
  logic byte_stb;
  assign byte_stb = bit_stb && (bit_reg == 3'h7);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_reg <= 8'h00;
      bit_reg <= 3'h0;
      nbyte_reg <= 4'h0;
    end else if (ce) begin
      if (!frame_s) begin
        bit_reg <= 3'h0;
        if (frame_end) nbyte_reg <= 4'h0;
      end else if (bit_stb) begin
        sh_reg <= {dat_s, sh_reg[7:1]};
        bit_reg <= bit_reg + 3'h1;
        if (byte_stb && nbyte_reg != 4'hF)
          nbyte_reg <= nbyte_reg + 4'h1;
      end
    end
  end
  logic [7:0] byte_in;
  assign byte_in = {dat_s, sh_reg[7:1]};
  // request bytes: cmd, addr, data lsb..msb, crc lo, hi
  always_ff @(posedge clk) begin
    if (ce && byte_stb && nbyte_reg < 4'(tbw_pkg::MAX_REQ + 2))
      rq[nbyte_reg] <= byte_in;
  end

  // request crc check, residue of a good frame
  logic [15:0] rx_crc;
  tbw_crc u_rx_crc (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .clr(frame_end),
    .en(byte_stb),
    .din(byte_in),
    .crc(rx_crc)
  );
  logic crc_ok, frame_done_reg, crc_ok_reg;
  // latch crc verdict at frame end; preset comes back next cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_done_reg <= 1'b0;
      crc_ok_reg <= 1'b0;
    end else if (ce) begin
      frame_done_reg <= frame_end;
      if (frame_end)
        crc_ok_reg <= (rx_crc == 16'hF0B8);
    end
  end
  assign crc_ok = crc_ok_reg;
  logic [3:0] len_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) len_reg <= 4'h0;
    else if (ce && frame_end) len_reg <= nbyte_reg;
  end

  // command decode
  tbw_pkg::tbw_state_t st_reg;
  logic [7:0] slot_tag_code_reg;
  logic [31:0] prog_reg;
  logic go, is_init, is_sel, is_wr, is_fetch, addr_ok, writable;
  logic [7:0] cmd, addr;
  assign cmd = rq[0];
  assign addr = rq[1];
  assign go = ce && frame_done_reg && crc_ok && !busy;
  assign is_init = go && len_reg == 4'h4 && cmd == tbw_pkg::CMD_INITIATE
    && addr == 8'h00;
  assign is_sel = go && len_reg == 4'h4 && cmd == tbw_pkg::CMD_SELECT;
  assign is_wr = go && len_reg == 4'h8 && cmd == tbw_pkg::CMD_WRITE
    && st_reg == tbw_pkg::TBW_SELECTED;
  assign is_fetch = go && len_reg == 4'h3 && cmd == tbw_pkg::CMD_FETCH
    && st_reg == tbw_pkg::TBW_SELECTED;
  assign addr_ok = (addr <= tbw_pkg::ADDR_LAST_BLOCK)
    || (addr == tbw_pkg::ADDR_SYSTEM);
  // system area is not held here, so only blocks 0..15 take data
  assign writable = (addr <= tbw_pkg::ADDR_LAST_BLOCK)
    && !PROT_MASK[addr[3:0]];

  // state machine; ready only takes initiate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= tbw_pkg::TBW_READY;
      slot_tag_code_reg <= tbw_pkg::SLOT_TAG_RESET;
    end else if (ce) begin
      case (st_reg)
        tbw_pkg::TBW_READY, tbw_pkg::TBW_INVENTORY: begin
          if (is_init) begin
            st_reg <= tbw_pkg::TBW_INVENTORY;
            slot_tag_code_reg <= {slot_tag_code_reg[3:0],
              slot_tag_code_reg[7:4]} ^ 8'h1D;
          end else if (is_sel && st_reg == tbw_pkg::TBW_INVENTORY
              && addr == slot_tag_code_reg)
            st_reg <= tbw_pkg::TBW_SELECTED;
        end
        tbw_pkg::TBW_SELECTED: begin
          if (is_sel && addr != slot_tag_code_reg)
            st_reg <= tbw_pkg::TBW_DEACT;
        end
        tbw_pkg::TBW_DEACT: begin
          if (is_sel && addr == slot_tag_code_reg)
            st_reg <= tbw_pkg::TBW_SELECTED;
        end
        default: st_reg <= tbw_pkg::TBW_READY;
      endcase
    end
  end
  assign selected = (st_reg == tbw_pkg::TBW_SELECTED);
  assign low_power = (st_reg == tbw_pkg::TBW_READY);

  // block store, otp clears only, counters only decrement
  logic [31:0] wdata;
  assign wdata = {rq[5], rq[4], rq[3], rq[2]};
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_blk
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) blk_data[g] <= 32'hFFFFFFFF;
        else if (is_wr && addr_ok && writable && addr[3:0] == 4'(g)) begin
          if (g <= int'(tbw_pkg::ADDR_LAST_OTP))
            blk_data[g] <= blk_data[g] & wdata;
          else if (g <= int'(tbw_pkg::ADDR_LAST_CNT)) begin
            if (wdata < blk_data[g]) blk_data[g] <= wdata;
          end else
            blk_data[g] <= wdata;
        end
      end
    end
  endgenerate

  // self-timed programming; requests dropped meanwhile
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) prog_reg <= 32'h0;
    else if (ce) begin
      if (is_wr && addr_ok && writable) begin
        if (addr <= tbw_pkg::ADDR_LAST_OTP) prog_reg <= PROG_OTP;
        else if (addr <= tbw_pkg::ADDR_LAST_CNT)
          prog_reg <= PROG_CNT;
        else prog_reg <= PROG_EE;
      end else if (prog_reg != 32'h0)
        prog_reg <= prog_reg - 32'h1;
    end
  end
  assign busy = (prog_reg != 32'h0);

  // answer sequencer; writes never start one
  logic [63:0] unique_serial_identifier;
  assign unique_serial_identifier = {tbw_pkg::ID_PREFIX, tbw_pkg::ID_MAKER,
    tbw_pkg::ID_PRODUCT, tbw_pkg::ID_SERIAL};
  logic [3:0] tx_idx_reg, tx_len_reg;
  logic tx_on_reg, tx_is_uid_reg;
  logic [7:0] tx_byte;
  logic [15:0] tx_crc, tx_crc_inv;
  logic b_in_ready, b_push;
  assign tx_crc_inv = ~tx_crc;
  always_comb begin
    if (tx_idx_reg == tx_len_reg - 4'h2) tx_byte = tx_crc_inv[7:0];
    else if (tx_idx_reg == tx_len_reg - 4'h1) tx_byte = tx_crc_inv[15:8];
    else if (tx_is_uid_reg)
      tx_byte = unique_serial_identifier[{tx_idx_reg[2:0], 3'h0} +: 8];
    else tx_byte = slot_tag_code_reg;
  end
  assign b_push = tx_on_reg && b_in_ready;
  tbw_crc u_tx_crc (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .clr(!tx_on_reg),
    .en(b_push && tx_idx_reg < tx_len_reg - 4'h2),
    .din(tx_byte),
    .crc(tx_crc)
  );
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_on_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_len_reg <= 4'h0;
      tx_is_uid_reg <= 1'b0;
    end else if (ce) begin
      if (!tx_on_reg) begin
        tx_idx_reg <= 4'h0;
        if (is_fetch) begin
          tx_on_reg <= 1'b1;
          tx_is_uid_reg <= 1'b1;
          tx_len_reg <= 4'(tbw_pkg::RSP_LEN);
        end else if (is_init || (is_sel && addr == slot_tag_code_reg
            && st_reg != tbw_pkg::TBW_READY)) begin
          tx_on_reg <= 1'b1;
          tx_is_uid_reg <= 1'b0;
          tx_len_reg <= 4'h3;
        end
      end else if (b_push) begin
        tx_idx_reg <= tx_idx_reg + 4'h1;
        if (tx_idx_reg == tx_len_reg - 4'h1) tx_on_reg <= 1'b0;
      end
    end
  end
  // answer buffer; block write goes nowhere near it
  logic [8:0] b_out;
  tbw_buf #(.W(9)) u_buf (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(tx_on_reg),
    .in_ready(b_in_ready),
    .in_data({tx_idx_reg == tx_len_reg - 4'h1, tx_byte}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(b_out)
  );
  assign tx_data = b_out[7:0];
  assign tx_last = b_out[8];
  // modulate only while answering; idle shows highest impedance
  assign load_mod = tx_valid;
endmodule : tbw_core

// >>> rtl/tbw_pkg.sv
// constants for the tag block-write / identifier-fetch command core
// assumes a bit-serial frame link outside; no software registers
// How it works
// - write command 09h stores four data bytes
// - write only available, unprotected blocks
// - data bytes LSB first, bits LSB first
// - addresses 0-15 and 255; others dropped silently; here a write to 255 is dropped as well, no system area held
// - route by address: otp, counters, storage
// - block write never answers
// - write ignored unless in selected state
// - write frame: cmd, addr, 4 data, crc
// - fetch 0Bh answers eight id bytes, crc
// - id bytes sent least significant first
// - fetch ignored unless in selected state
// - id = prefix, maker, product, serial fields
// - power-on enters ready, low-power
// - power-on applies no load modulation
// - power-on answers only anticollision opening
// - select 0Eh with matching code selects
// - write finishes in 3, 5, 7 ms
// - crc x16+x12+x5+1, preset FFFF, inverted
package tbw_pkg;
  localparam logic [7:0] CMD_INITIATE = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h09;
  localparam logic [7:0] CMD_FETCH = 8'h0B;
  localparam logic [7:0] CMD_SELECT = 8'h0E;
  localparam logic [7:0] ADDR_SYSTEM = 8'hFF;
  localparam logic [7:0] ADDR_LAST_BLOCK = 8'h0F;
  localparam logic [7:0] ADDR_LAST_OTP = 8'h04;
  localparam logic [7:0] ADDR_LAST_CNT = 8'h06;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam int CLK_HZ = 40000000;
  localparam int T_OTP_US = 3000;
  localparam int T_EE_US = 5000;
  localparam int T_CNT_US = 7000;
  localparam int CYC_OTP = T_OTP_US * (CLK_HZ / 1000000);
  localparam int CYC_EE = T_EE_US * (CLK_HZ / 1000000);
  localparam int CYC_CNT = T_CNT_US * (CLK_HZ / 1000000);
  localparam int MAX_REQ = 7;
  localparam int RSP_LEN = 10;
  localparam logic [7:0] ID_PREFIX = 8'hA5; // arbitrary value
  localparam logic [7:0] ID_MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] ID_PRODUCT = 8'h3C; // arbitrary value
  localparam logic [39:0] ID_SERIAL = 40'h0123456789; // arbitrary value
  localparam logic [7:0] SLOT_TAG_RESET = 8'h00;
  typedef enum logic [1:0] {
    TBW_READY, TBW_INVENTORY, TBW_SELECTED, TBW_DEACT
  } tbw_state_t;
endpackage : tbw_pkg

// >>> rtl/tbw_crc.sv
// frame crc accumulator, one byte per enable
// assumes bytes arrive in frame order, bit 0 first
`timescale 1ns/1ps
module tbw_crc (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic clr, // restart with preset
  input wire logic en, // absorb one byte
  input wire logic [7:0] din, // byte in
  output logic [15:0] crc // running value, not inverted
);
  logic [15:0] crc_next;
  // lsb-first reflected update of x16+x12+x5+1
  always_comb begin
    logic [7:0] c;
    c = din ^ crc[7:0];
    c = c ^ (c << 4);
    crc_next = (crc >> 8) ^ {c, 8'h00} ^ {5'h00, c, 3'h0}
      ^ {12'h000, c[7:4]};
  end
  // register, preset on clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) crc <= tbw_pkg::CRC_PRESET;
    else if (ce) begin
      if (clr) crc <= tbw_pkg::CRC_PRESET;
      else if (en) crc <= crc_next;
    end
  end
endmodule : tbw_crc

// >>> rtl/tbw_buf.sv
// two-entry valid/ready buffer on the answer path
// assumes same clock on both sides
`timescale 1ns/1ps
module tbw_buf #(
  parameter int W = 9 // word width
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic in_valid, // word offered
  output logic in_ready, // room left
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // taker ready
  output logic [W-1:0] out_data // word out
);
  logic [W-1:0] mem [2];
  logic rd_reg, wr_reg;
  logic [1:0] cnt_reg;
  logic push, pop;
  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem[rd_reg];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  // storage, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) mem[wr_reg] <= in_data;
  end
  // pointers and fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : tbw_buf

// >>> dv/tbw_core_checker.sv
// port assertions for the command core
// assumes it is bound into each tbw_core
`timescale 1ns/1ps
module tbw_core_checker #(
  parameter int unsigned PROG_CNT = 70, // longest write count
  parameter logic [15:0] PROT_MASK = 16'h0000 // locked blocks
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic tx_valid, // answer byte offered
  input wire logic tx_ready, // answer byte taken
  input wire logic [7:0] tx_data, // answer byte
  input wire logic tx_last, // last answer byte
  input wire logic load_mod, // load modulation
  input wire logic low_power, // low-power condition
  input wire logic selected, // selected state
  input wire logic busy, // programming runs
  input wire logic [31:0] blk_data [16] // block contents
);
  logic [511:0] flat;
  logic [511:0] pmask;
  int unsigned bcnt;
  // packed copies, since array change tests vary between tools
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      flat[32*i+:32] = blk_data[i];
      pmask[32*i+:32] = {32{PROT_MASK[i]}};
    end
  end
  // length of the current programming run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) bcnt <= 0;
    else if (ce) bcnt <= busy ? bcnt + 1 : 0; // frozen cycles do not count
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_WAKE: assert property (
    $rose(resetn) |-> low_power && !selected && !busy)
    else $error("not in ready state after reset");
  AST_QUIET: assert property (
    load_mod == tx_valid) else $error("load modulation without answer");
  AST_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("answer byte dropped before taken");
  AST_SILENT: assert property (
    busy |-> !tx_valid) else $error("answer during write");
  AST_SEL: assert property (
    $rose(busy) |-> selected) else $error("write while not selected");
  AST_PROG_MIN: assert property (
    $rose(busy) |-> busy[*8]) else $error("programming too short");
  AST_PROG_MAX: assert property (
    bcnt <= PROG_CNT + 2) else $error("programming too long");
  AST_WR_BUSY: assert property (
    flat != $past(flat) |-> ##[0:1] busy) else $error("store without busy");
  AST_LOCKED: assert property (
    (flat & pmask) == ($past(flat) & pmask))
    else $error("locked block changed");
  AST_LAST: assert property (
    tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("bytes after last");
  // ready state has not answered anything yet, so the field stays unloaded
  AST_READY_QUIET: assert property (
    low_power |-> !tx_valid && !load_mod)
    else $error("answer while in ready state");
  AST_FROZEN: assert property (
    !ce |=> $stable(busy) && $stable(flat))
    else $error("state moved while clock enable low");
endmodule : tbw_core_checker

bind tbw_core tbw_core_checker #(.PROG_CNT(PROG_CNT), .PROT_MASK(PROT_MASK))
  u_tbw_core_checker (.clk(clk), .resetn(resetn), .ce(ce),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
  .load_mod(load_mod), .low_power(low_power), .selected(selected),
  .busy(busy), .blk_data(blk_data));

// >>> dv/tbw_reader.sv
// reader model: bit-serial request frames and a stalling answer sink
// assumes the core samples link data on the link clock rise
`timescale 1ns/1ps
module tbw_reader #(
  parameter int SEED = 32'h1F2E3D4C // stall pattern seed
) (
  input wire logic clk, // system clock
  output logic rx_clk, // link bit clock
  output logic rx_dat, // link data
  output logic rx_frame, // request frame window
  input wire logic tx_valid, // answer byte offered
  input wire logic [7:0] tx_data, // answer byte
  input wire logic tx_last, // last answer byte
  output logic tx_ready // answer byte taken
);
  logic [8:0] rsp [$];
  int sd = SEED;
  initial begin
    rx_clk = 0;
    rx_dat = 0;
    rx_frame = 0;
  end
  // stall about half the time so the answer buffer fills
  always @(posedge clk) begin
    if (tx_valid && tx_ready) rsp.push_back({tx_last, tx_data});
    tx_ready <= ($random(sd) & 32'h1) != 0;
  end
  // 200 ns link clock, still between frames, offset from clk edges
  task automatic send(input logic [7:0] q [$]);
    #3;
    rx_frame = 1;
    #150;
    foreach (q[i]) for (int b = 0; b < 8; b++) begin
      rx_dat = q[i][b];
      #100;
      rx_clk = 1;
      #100;
      rx_clk = 0;
    end
    #150;
    rx_frame = 0;
    rx_dat = ~rx_dat; // released line shows no stale bit
  endtask : send
endmodule : tbw_reader

// >>> dv/tbw_core_tb.sv
// self-checking bench for the command core against the reader model
// assumes shortened programming counts and block 8 locked
`timescale 1ns/1ps
module tbw_core_tb;
  typedef logic [7:0] tbw_bq_t [$];
  localparam logic [15:0] PROT = 16'h0100;
  localparam logic [63:0] UNIQUE_SERIAL_IDENTIFIER = {tbw_pkg::ID_PREFIX, tbw_pkg::ID_MAKER,
    tbw_pkg::ID_PRODUCT, tbw_pkg::ID_SERIAL};
  logic clk = 0;
  logic resetn = 0;
  logic ce = 1;
  logic rx_clk, rx_dat, rx_frame, tx_valid, tx_ready, tx_last;
  logic load_mod, low_power, selected, busy;
  logic [7:0] tx_data;
  logic [7:0] code;
  logic [31:0] blk_data [16];
  logic [31:0] mem [16];
  logic [7:0] adr [12] = '{8'h07, 8'h0F, 8'h00, 8'h0A, 8'h00, 8'h05,
    8'h05, 8'h06, 8'h08, 8'h10, 8'hFF, 8'h04};
  bit sel = 0;
  int seed = 32'h7E6112FF;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  tbw_core #(.PROG_OTP(1500), .PROG_EE(2000), .PROG_CNT(2500),
    .PROT_MASK(PROT)) u_tbw_core (.clk(clk), .resetn(resetn), .ce(ce),
    .rx_clk(rx_clk), .rx_dat(rx_dat), .rx_frame(rx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .load_mod(load_mod), .low_power(low_power),
    .selected(selected), .busy(busy), .blk_data(blk_data));
  tbw_reader u_tbw_reader (.clk(clk), .rx_clk(rx_clk), .rx_dat(rx_dat),
    .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));
  initial forever #12.5 clk = ~clk;
  // frame check value, inverted as sent
  function automatic logic [15:0] crc_b(tbw_bq_t q);
    logic [15:0] c;
    logic [7:0] ch;
    c = 16'hFFFF;
    foreach (q[i]) begin
      ch = q[i] ^ c[7:0];
      ch = ch ^ (ch << 4);
      c = (c >> 8) ^ {ch, 8'h00} ^ {5'h00, ch, 3'h0} ^ {12'h000, ch[7:4]};
    end
    return ~c;
  endfunction : crc_b
  // expected effect of one accepted store
  function automatic void model_wr(logic [7:0] a, logic [31:0] d);
    if (a > 8'h0F || PROT[a[3:0]]) return;
    if (a <= 8'h04) mem[a] &= d;
    else if (a <= 8'h06) mem[a] = (d < mem[a]) ? d : mem[a];
    else mem[a] = d;
  endfunction : model_wr
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one request with its check value, spoiled on demand
  task automatic req(tbw_bq_t q, bit bad = 0);
    logic [15:0] c;
    c = crc_b(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    u_tbw_reader.rsp.delete();
    @(posedge clk);
    u_tbw_reader.send(q);
    repeat (40) @(posedge clk);
  endtask : req
  // bounded wait for programming and n answer bytes
  task automatic settle(int n);
    for (int i = 0; i < 4000 && (busy !== 1'b0 ||
      u_tbw_reader.rsp.size() < n); i++) @(posedge clk);
    chk(u_tbw_reader.rsp.size(), n);
    chk(busy, 0);
  endtask : settle
  task automatic ans_ok(int n);
    tbw_bq_t q;
    foreach (u_tbw_reader.rsp[i]) begin
      if (i < n - 2) q.push_back(u_tbw_reader.rsp[i][7:0]);
      chk(u_tbw_reader.rsp[i][8], i == n - 1);
    end
    chk({u_tbw_reader.rsp[n-1][7:0], u_tbw_reader.rsp[n-2][7:0]},
      crc_b(q));
  endtask : ans_ok
  task automatic wr(logic [7:0] a, logic [31:0] d, bit bad = 0);
    req({tbw_pkg::CMD_WRITE, a, d[7:0], d[15:8], d[23:16], d[31:24]}, bad);
    if (sel && !bad) model_wr(a, d);
    settle(0);
    foreach (mem[i]) chk(blk_data[i], mem[i]);
  endtask : wr
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
    repeat (20) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    chk({low_power, selected, load_mod}, 3'b100);
    req({tbw_pkg::CMD_FETCH});
    settle(0);
    wr(8'h07, 32'h12345678);
    req({tbw_pkg::CMD_INITIATE, 8'h00});
    settle(3);
    ans_ok(3);
    code = u_tbw_reader.rsp[0][7:0];
    req({tbw_pkg::CMD_SELECT, code});
    settle(3);
    ans_ok(3);
    sel = 1;
    chk({selected, low_power}, 2'b10);
    chk(u_tbw_reader.rsp[0][7:0], code);
    req({tbw_pkg::CMD_FETCH});
    settle(10);
    ans_ok(10);
    for (int i = 0; i < 8; i++)
      chk(u_tbw_reader.rsp[i][7:0], UNIQUE_SERIAL_IDENTIFIER[8*i+:8]);
    foreach (adr[i]) wr(adr[i], $random(seed), i == 3);
    wr(8'h05, 32'hFFFFFFFF);
    req({tbw_pkg::CMD_WRITE, 8'h09, 8'h11, 8'h22, 8'h33, 8'h44});
    model_wr(8'h09, 32'h44332211);
    chk(busy, 1);
    // longer than the whole count: only a frozen count keeps busy up
    ce <= 1'b0;
    repeat (2500) @(posedge clk);
    chk(busy, 1);
    ce <= 1'b1;
    // busy core must drop this store, so the model leaves it out
    sel = 0;
    wr(8'h0B, 32'h88776655);
    sel = 1;
    req({tbw_pkg::CMD_SELECT, code ^ 8'h01});
    settle(0);
    sel = 0;
    chk(selected, 0);
    req({tbw_pkg::CMD_FETCH});
    settle(0);
    wr(8'h07, 32'h00000000);
    // deselected tag comes back on its own code
    req({tbw_pkg::CMD_SELECT, code});
    settle(3);
    ans_ok(3);
    chk(selected, 1);
    results();
  end
endmodule : tbw_core_tb
